// [rtl/osm_consts.vh]
// Purpose: Shared constants of the OR, shift, copy and indirect-load slice
// Assumes: APB register map, byte addresses in the low eight address bits
// Notes:   Included by every design file of the block
`ifndef OSM_CONSTS_VH
`define OSM_CONSTS_VH

// Register byte offsets
`define OSM_REG_CMD      8'h00
`define OSM_REG_ACC      8'h04
`define OSM_REG_FLAGS    8'h08
`define OSM_REG_PTR0     8'h0c
`define OSM_REG_PTR1     8'h10
`define OSM_REG_BANK     8'h14
`define OSM_REG_STAT     8'h18
`define OSM_REG_RESULT   8'h1c
`define OSM_REG_LASTEA   8'h20

// Instruction word fields in the command register
`define OSM_CMD_OP_MSB   2
`define OSM_CMD_OP_LSB   0
`define OSM_CMD_DEST     3
`define OSM_CMD_PSEL     4
`define OSM_CMD_REL      5
`define OSM_CMD_MODE_MSB 7
`define OSM_CMD_MODE_LSB 6
`define OSM_CMD_OFS_MSB  13
`define OSM_CMD_OFS_LSB  8
`define OSM_CMD_IDX_MSB  22
`define OSM_CMD_IDX_LSB  16

// Operation codes
`define OSM_OP_OR        3'h0
`define OSM_OP_SHL       3'h1
`define OSM_OP_SHR       3'h2
`define OSM_OP_COPY      3'h3
`define OSM_OP_LDI       3'h4

// Pointer update codes
`define OSM_MODE_PREINC  2'h0
`define OSM_MODE_PREDEC  2'h1
`define OSM_MODE_POSTINC 2'h2
`define OSM_MODE_POSTDEC 2'h3

// Flag and status bit positions
`define OSM_FLAG_C       0
`define OSM_FLAG_Z       2
`define OSM_STAT_BUSY    0
`define OSM_STAT_DONE    1
`define OSM_STAT_REFUSED 2

// Indirect window file indices
`define OSM_WIN0_IDX     7'h00
`define OSM_WIN1_IDX     7'h01

// Reset values
`define OSM_RST_ACC      8'h00
`define OSM_RST_PTR      16'h0000
`define OSM_RST_BANK     5'h00

`endif

// [rtl/osm_ea_calc.v]
// Purpose: Effective address and next pointer for one indirect access
// Assumes: Purely combinational, pointer arithmetic is 16-bit
// Notes:   Carries no flag out; pointer stepping never touches status
`timescale 1ns/10ps
`include "osm_consts.vh"

module osm_ea_calc #(
  parameter PW = 16
) (
  input  wire [PW-1:0] ptr,
  input  wire [1:0]    mode,
  input  wire          relative,
  input  wire [5:0]    offset,
  output reg  [PW-1:0] ea,
  output reg  [PW-1:0] ptr_new
);

  wire [PW-1:0] one_w  = {{(PW-1){1'b0}}, 1'b1};
  wire [PW-1:0] sext_w = {{(PW-6){offset[5]}}, offset};
  // Carry out dropped on purpose: wrap around the pointer range
  wire [PW:0]   inc_w  = {1'b0, ptr} + {1'b0, one_w};
  wire [PW:0]   dec_w  = {1'b0, ptr} - {1'b0, one_w};
  wire [PW:0]   rel_w  = {1'b0, ptr} + {1'b0, sext_w};

  always @* begin
    ea      = ptr;
    ptr_new = ptr;
    if (relative) begin
      ea      = rel_w[PW-1:0];
      ptr_new = ptr;
    end else begin
      case (mode)
        `OSM_MODE_PREINC: begin
          ea      = inc_w[PW-1:0];
          ptr_new = inc_w[PW-1:0];
        end
        `OSM_MODE_PREDEC: begin
          ea      = dec_w[PW-1:0];
          ptr_new = dec_w[PW-1:0];
        end
        `OSM_MODE_POSTINC: begin
          ea      = ptr;
          ptr_new = inc_w[PW-1:0];
        end
        `OSM_MODE_POSTDEC: begin
          ea      = ptr;
          ptr_new = dec_w[PW-1:0];
        end
        default: begin
          ea      = ptr;
          ptr_new = ptr;
        end
      endcase
    end
  end

endmodule

// [rtl/osm_exec.v]
// Purpose: Executes OR, shifts, copy and indirect load for one core slice
// Assumes: APB slave for control, req/ack data memory port on the far side
// Notes:   One command in flight; commands while busy are refused
//
// Chosen here: the address map and the APB slave port.
`timescale 1ns/10ps
`include "osm_consts.vh"

module osm_exec #(
  parameter AW = 12
) (
  input  wire          mclk,
  input  wire          sys_rst,
  input  wire          psel,
  input  wire          penable,
  input  wire          pwrite,
  input  wire [AW-1:0] paddr,
  input  wire [31:0]   pwdata,
  output wire [31:0]   prdata,
  output wire          pready,
  output wire          pslverr,
  output wire          mem_req,
  output wire          mem_we,
  output wire [15:0]   mem_addr,
  output wire [7:0]    mem_wdata,
  input  wire [7:0]    mem_rdata,
  input  wire          mem_ack
);

  localparam ST_IDLE = 2'h0;
  localparam ST_READ = 2'h1;
  localparam ST_WRIT = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // State

  reg  [1:0]  state_reg;
  reg  [7:0]  acc_reg;
  reg         flag_c_reg;
  reg         flag_z_reg;
  reg  [15:0] ptr0_reg;
  reg  [15:0] ptr1_reg;
  reg  [4:0]  bank_reg;
  reg         done_reg;
  reg         refused_reg;
  reg  [7:0]  result_reg;
  reg  [31:0] cmd_reg;
  reg  [2:0]  op_reg;
  reg         dest_reg;
  reg         psel_reg;
  reg  [15:0] ptr_new_reg;
  reg         mem_req_reg;
  reg         mem_we_reg;
  reg  [15:0] mem_addr_reg;
  reg  [7:0]  mem_wdata_reg;
  reg  [31:0] prdata_reg;
  reg  [31:0] rd_mux;
  reg         addr_ok;
  reg  [7:0]  res_next;
  reg         carry_next;
  reg         carry_upd;
  reg  [15:0] launch_addr;

  wire        busy      = (state_reg != ST_IDLE);
  wire [7:0]  reg_addr  = paddr[7:0];
  wire        hi_zero   = (paddr[AW-1:8] == {(AW-8){1'b0}});
  wire        apb_setup = psel & ~penable;
  wire        apb_acc   = psel & penable;
  wire        apb_wr    = apb_acc & pwrite;

  wire [2:0]  c_op   = pwdata[`OSM_CMD_OP_MSB:`OSM_CMD_OP_LSB];
  wire        c_dest = pwdata[`OSM_CMD_DEST];
  wire        c_psel = pwdata[`OSM_CMD_PSEL];
  wire        c_rel  = pwdata[`OSM_CMD_REL];
  wire [1:0]  c_mode = pwdata[`OSM_CMD_MODE_MSB:`OSM_CMD_MODE_LSB];
  wire [5:0]  c_ofs  = pwdata[`OSM_CMD_OFS_MSB:`OSM_CMD_OFS_LSB];
  wire [6:0]  c_idx  = pwdata[`OSM_CMD_IDX_MSB:`OSM_CMD_IDX_LSB];
  wire        c_legal = (c_op <= `OSM_OP_LDI);

  // Writes that would race the running command are refused
  wire        sel_cmd  = hi_zero & (reg_addr == `OSM_REG_CMD);
  wire        sel_stat = hi_zero & (reg_addr == `OSM_REG_STAT);
  wire        wr_block = busy & ~sel_stat;
  wire        cmd_go   = apb_wr & sel_cmd & ~busy & c_legal;
  wire        cmd_bad  = apb_wr & sel_cmd & ~(~busy & c_legal);
  wire        wr_ok    = apb_wr & addr_ok & ~wr_block;
  wire        rd_done  = (state_reg == ST_READ) & mem_ack;
  wire        wr_done  = (state_reg == ST_WRIT) & mem_ack;
  wire        finish   = (rd_done & ~(dest_reg & (op_reg != `OSM_OP_LDI)))
                         | wr_done;

  wire [15:0] sel_ptr  = c_psel ? ptr1_reg : ptr0_reg;
  wire [15:0] ea_w;
  wire [15:0] ptr_new_w;

  osm_ea_calc #(
    .PW       (16)
  ) u_ea (
    .ptr      (sel_ptr),
    .mode     (c_mode),
    .relative (c_rel),
    .offset   (c_ofs),
    .ea       (ea_w),
    .ptr_new  (ptr_new_w)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Address of the access at launch

  always @* begin
    launch_addr = {4'h0, bank_reg, c_idx};
    if (c_op == `OSM_OP_LDI) begin
      launch_addr = ea_w;
    end else if (c_idx == `OSM_WIN0_IDX) begin
      launch_addr = ptr0_reg;
    end else if (c_idx == `OSM_WIN1_IDX) begin
      launch_addr = ptr1_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Datapath on the operand returned by memory

  always @* begin
    res_next   = mem_rdata;
    carry_next = flag_c_reg;
    carry_upd  = 1'b0;
    case (op_reg)
      `OSM_OP_OR: begin
        res_next = acc_reg | mem_rdata;
      end
      `OSM_OP_SHL: begin
        res_next   = {mem_rdata[6:0], 1'b0};
        carry_next = mem_rdata[7];
        carry_upd  = 1'b1;
      end
      `OSM_OP_SHR: begin
        res_next   = {1'b0, mem_rdata[7:1]};
        carry_next = mem_rdata[0];
        carry_upd  = 1'b1;
      end
      `OSM_OP_COPY: begin
        res_next = mem_rdata;
      end
      `OSM_OP_LDI: begin
        res_next = mem_rdata;
      end
      default: begin
        res_next = mem_rdata;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer: read operand, optional write-back

  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg     <= ST_IDLE;
      op_reg        <= `OSM_OP_OR;
      dest_reg      <= 1'b0;
      psel_reg      <= 1'b0;
      ptr_new_reg   <= `OSM_RST_PTR;
      mem_req_reg   <= 1'b0;
      mem_we_reg    <= 1'b0;
      mem_addr_reg  <= 16'h0000;
      mem_wdata_reg <= 8'h00;
      cmd_reg       <= 32'h00000000;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (cmd_go) begin
            cmd_reg      <= pwdata;
            op_reg       <= c_op;
            dest_reg     <= c_dest;
            psel_reg     <= c_psel;
            ptr_new_reg  <= ptr_new_w;
            mem_addr_reg <= launch_addr;
            mem_we_reg   <= 1'b0;
            mem_req_reg  <= 1'b1;
            state_reg    <= ST_READ;
          end
        end
        ST_READ: begin
          if (mem_ack) begin
            if (dest_reg && (op_reg != `OSM_OP_LDI)) begin
              mem_wdata_reg <= res_next;
              mem_we_reg    <= 1'b1;
              state_reg     <= ST_WRIT;
            end else begin
              mem_req_reg <= 1'b0;
              state_reg   <= ST_IDLE;
            end
          end
        end
        ST_WRIT: begin
          if (mem_ack) begin
            mem_req_reg <= 1'b0;
            mem_we_reg  <= 1'b0;
            state_reg   <= ST_IDLE;
          end
        end
        default: begin
          mem_req_reg <= 1'b0;
          mem_we_reg  <= 1'b0;
          state_reg   <= ST_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Architectural registers: software writes and command results

  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      acc_reg    <= `OSM_RST_ACC;
      flag_c_reg <= 1'b0;
      flag_z_reg <= 1'b0;
      ptr0_reg   <= `OSM_RST_PTR;
      ptr1_reg   <= `OSM_RST_PTR;
      bank_reg   <= `OSM_RST_BANK;
      result_reg <= 8'h00;
    end else if (rd_done) begin
      result_reg <= res_next;
      flag_z_reg <= (res_next == 8'h00);
      if (carry_upd) begin
        flag_c_reg <= carry_next;
      end
      if ((op_reg == `OSM_OP_LDI) || !dest_reg) begin
        acc_reg <= res_next;
      end
      // Pointer step commits after the access and leaves flags alone
      if (op_reg == `OSM_OP_LDI) begin
        if (psel_reg) begin
          ptr1_reg <= ptr_new_reg;
        end else begin
          ptr0_reg <= ptr_new_reg;
        end
      end
    end else if (wr_ok) begin
      case (reg_addr)
        `OSM_REG_ACC: begin
          acc_reg <= pwdata[7:0];
        end
        `OSM_REG_FLAGS: begin
          flag_c_reg <= pwdata[`OSM_FLAG_C];
          flag_z_reg <= pwdata[`OSM_FLAG_Z];
        end
        `OSM_REG_PTR0: begin
          ptr0_reg <= pwdata[15:0];
        end
        `OSM_REG_PTR1: begin
          ptr1_reg <= pwdata[15:0];
        end
        `OSM_REG_BANK: begin
          bank_reg <= pwdata[4:0];
        end
        default: begin
          bank_reg <= bank_reg;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sticky status; a new event wins over a same-cycle clear

  wire stat_clr = apb_wr & sel_stat;

  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      done_reg    <= 1'b0;
      refused_reg <= 1'b0;
    end else begin
      if (finish) begin
        done_reg <= 1'b1;
      end else if (stat_clr && pwdata[`OSM_STAT_DONE]) begin
        done_reg <= 1'b0;
      end
      if (cmd_bad) begin
        refused_reg <= 1'b1;
      end else if (stat_clr && pwdata[`OSM_STAT_REFUSED]) begin
        refused_reg <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB read path, captured in the setup cycle

  always @* begin
    rd_mux  = 32'h00000000;
    addr_ok = hi_zero;
    case (reg_addr)
      `OSM_REG_CMD:    rd_mux = cmd_reg;
      `OSM_REG_ACC:    rd_mux = {24'h000000, acc_reg};
      `OSM_REG_FLAGS:  rd_mux = {29'h00000000, flag_z_reg, 1'b0, flag_c_reg};
      `OSM_REG_PTR0:   rd_mux = {16'h0000, ptr0_reg};
      `OSM_REG_PTR1:   rd_mux = {16'h0000, ptr1_reg};
      `OSM_REG_BANK:   rd_mux = {27'h0000000, bank_reg};
      `OSM_REG_STAT:   rd_mux = {29'h00000000, refused_reg, done_reg, busy};
      `OSM_REG_RESULT: rd_mux = {24'h000000, result_reg};
      `OSM_REG_LASTEA: rd_mux = {16'h0000, mem_addr_reg};
      default: begin
        rd_mux  = 32'h00000000;
        addr_ok = 1'b0;
      end
    endcase
    if (!hi_zero) begin
      rd_mux = 32'h00000000;
    end
  end

  // Read data can be one cycle stale if a command finishes mid-transfer
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      prdata_reg <= 32'h00000000;
    end else if (apb_setup) begin
      prdata_reg <= rd_mux;
    end
  end

  wire rd_only = (reg_addr == `OSM_REG_RESULT) | (reg_addr == `OSM_REG_LASTEA);

  assign prdata    = prdata_reg;
  assign pready    = 1'b1;
  assign pslverr   = apb_acc & (~addr_ok | (pwrite & (wr_block | rd_only))
                     | cmd_bad);
  assign mem_req   = mem_req_reg;
  assign mem_we    = mem_we_reg;
  assign mem_addr  = mem_addr_reg;
  assign mem_wdata = mem_wdata_reg;

endmodule

// [testbench/osm_exec_bench.sv]
// Purpose: Self-checking bench of the exec slice over APB
// Assumes: Bank 31 for file operands, flags preset with carry high
// Notes:   Memory latency is raised midway to stall the block
`timescale 1ns/10ps
`include "osm_consts.vh"
module osm_exec_bench;
  reg         mclk = 1'b0;
  reg         sys_rst = 1'b1;
  reg         psel = 1'b0;
  reg         penable = 1'b0;
  reg         pwrite = 1'b0;
  reg  [11:0] paddr = 12'h000;
  reg  [31:0] pwdata = 32'h0;
  reg  [3:0]  lat = 4'h0;
  reg  [31:0] rd;
  reg         err;
  wire [31:0] prdata;
  wire        pready, pslverr, mem_req, mem_we, mem_ack;
  wire [15:0] mem_addr;
  wire [7:0]  mem_wdata, mem_rdata;
  integer     fail_count = 0;
  integer     total_checks = 0;
  always #20 mclk = ~mclk;
  osm_exec #(.AW(12)) osm_exec_inst (.mclk(mclk), .sys_rst(sys_rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack));
  osm_mem_model osm_mem_model_inst (.mclk(mclk), .sys_rst(sys_rst),
    .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .lat(lat),
    .mem_ack(mem_ack));
  //////////////////////////////////////////////////////////////
  task end_sim;
    begin
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      total_checks = total_checks + 1;
      if (got !== exp) begin
        fail_count = fail_count + 1;
        $display("BAD %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task apb(input w, input [11:0] a, input [31:0] d);
    integer n;
    begin
      @(posedge mclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge mclk);
      penable <= 1'b1;
      n = 0;
      @(posedge mclk);
      while (pready !== 1'b1 && n < 20) begin
        @(posedge mclk);
        n = n + 1;
      end
      rd  = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      if (n == 20)
        chk({31'h0, pready}, 32'h1);
    end
  endtask
  task rc(input [11:0] a, input [31:0] e);
    begin
      apb(1'b0, a, 32'h0);
      chk(rd, e);
    end
  endtask
  task run(input [31:0] c);
    integer n;
    begin
      apb(1'b1, `OSM_REG_CMD, c);
      n = 0;
      rd = 32'h1;
      while (rd[`OSM_STAT_BUSY] !== 1'b0 && n < 40) begin
        apb(1'b0, `OSM_REG_STAT, 32'h0);
        n = n + 1;
      end
      if (n == 40)
        chk(rd, 32'h0);
    end
  endtask
  task fop(input [2:0] op, input d, input [6:0] x, input [7:0] a,
           input [7:0] m, input [7:0] r, input [31:0] f);
    reg [15:0] ad;
    begin
      ad = {4'h0, 5'h1f, x};
      osm_mem_model_inst.mem[ad] = m;
      apb(1'b1, `OSM_REG_ACC, {24'h0, a});
      apb(1'b1, `OSM_REG_FLAGS, 32'h1);
      run({9'h0, x, 12'h0, d, op});
      rc(`OSM_REG_RESULT, {24'h0, r});
      rc(`OSM_REG_FLAGS, f);
      rc(`OSM_REG_ACC, {24'h0, d ? a : r});
      chk({24'h0, osm_mem_model_inst.mem[ad]}, {24'h0, d ? r : m});
    end
  endtask
  task ldi(input s, input r, input [1:0] md, input [5:0] o,
           input [15:0] p, input [15:0] ea, input [15:0] pn, input [7:0] v);
    reg [11:0] pa;
    begin
      pa = s ? `OSM_REG_PTR1 : `OSM_REG_PTR0;
      osm_mem_model_inst.mem[ea] = v;
      apb(1'b1, pa, {16'h0, p});
      apb(1'b1, `OSM_REG_FLAGS, 32'h1);
      run({18'h0, o, md, r, s, 1'b0, `OSM_OP_LDI});
      rc(`OSM_REG_ACC, {24'h0, v});
      rc(`OSM_REG_LASTEA, {16'h0, ea});
      rc(pa, {16'h0, pn});
      rc(`OSM_REG_FLAGS, v == 8'h0 ? 32'h5 : 32'h1);
    end
  endtask
  //////////////////////////////////////////////////////////////
  initial begin
    #200000;
    fail_count = fail_count + 1;
    end_sim;
  end
  initial begin
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    rc(`OSM_REG_PTR0, 32'h0);
    apb(1'b1, `OSM_REG_BANK, 32'h1f);
    fop(`OSM_OP_OR, 1'b0, 7'h10, 8'h0f, 8'hf0, 8'hff, 32'h1);
    fop(`OSM_OP_OR, 1'b1, 7'h7f, 8'h00, 8'h00, 8'h00, 32'h5);
    fop(`OSM_OP_SHL, 1'b0, 7'h20, 8'h11, 8'h81, 8'h02, 32'h1);
    fop(`OSM_OP_SHL, 1'b1, 7'h21, 8'h11, 8'h80, 8'h00, 32'h5);
    fop(`OSM_OP_SHL, 1'b0, 7'h26, 8'h11, 8'h40, 8'h80, 32'h0);
    lat <= 4'h3;
    fop(`OSM_OP_SHR, 1'b1, 7'h22, 8'h11, 8'h01, 8'h00, 32'h5);
    fop(`OSM_OP_SHR, 1'b0, 7'h23, 8'h11, 8'h82, 8'h41, 32'h0);
    fop(`OSM_OP_COPY, 1'b1, 7'h24, 8'h11, 8'h00, 8'h00, 32'h5);
    fop(`OSM_OP_COPY, 1'b0, 7'h25, 8'h11, 8'h5a, 8'h5a, 32'h1);
    apb(1'b1, `OSM_REG_PTR0, 32'h1234);
    osm_mem_model_inst.mem[16'h1234] = 8'h3c;
    run({16'h0, 13'h0, `OSM_OP_COPY});
    rc(`OSM_REG_ACC, 32'h3c);
    rc(`OSM_REG_PTR0, 32'h1234);
    ldi(0, 0, `OSM_MODE_PREINC, 0, 16'hffff, 16'h0, 16'h0, 8'h00);
    ldi(1, 0, `OSM_MODE_PREDEC, 0, 16'h0, 16'hffff, 16'hffff, 8'h77);
    lat <= 4'h0;
    ldi(0, 0, `OSM_MODE_POSTINC, 0, 16'hffff, 16'hffff, 16'h0, 8'h99);
    ldi(1, 0, `OSM_MODE_POSTDEC, 0, 16'h0, 16'h0, 16'hffff, 8'h00);
    ldi(0, 1, 2'h0, 6'h20, 16'h10, 16'hfff0, 16'h10, 8'h42);
    ldi(1, 1, 2'h3, 6'h1f, 16'h10, 16'h2f, 16'h10, 8'h24);
    osm_mem_model_inst.mem[16'h0010] = 8'h81;
    run(32'h00010009);
    rc(`OSM_REG_FLAGS, 32'h1);
    rc(`OSM_REG_PTR1, 32'h10);
    chk({24'h0, osm_mem_model_inst.mem[16'h0010]}, 32'h02);
    rc(`OSM_REG_STAT, 32'h2);
    apb(1'b1, `OSM_REG_STAT, 32'h6);
    rc(`OSM_REG_STAT, 32'h0);
    apb(1'b1, `OSM_REG_CMD, 32'h7);
    chk({31'h0, err}, 32'h1);
    rc(`OSM_REG_STAT, 32'h4);
    rc(`OSM_REG_CMD, 32'h00010009);
    apb(1'b1, `OSM_REG_RESULT, 32'h0);
    chk({31'h0, err}, 32'h1);
    apb(1'b0, 12'h100, 32'h0);
    chk({31'h0, err}, 32'h1);
    end_sim;
  end
endmodule

// [testbench/osm_exec_props.sv]
// Purpose: Port-level checks of the exec slice
// Assumes: Commands launch only while idle
// Notes:   Tracks the last command and read byte
`timescale 1ns/10ps
`include "osm_consts.vh"
module osm_exec_props #(
  parameter AW = 12
) (
  input wire          mclk,
  input wire          sys_rst,
  input wire          psel,
  input wire          penable,
  input wire          pwrite,
  input wire [AW-1:0] paddr,
  input wire [31:0]   pwdata,
  input wire [31:0]   prdata,
  input wire          pready,
  input wire          pslverr,
  input wire          mem_req,
  input wire          mem_we,
  input wire [15:0]   mem_addr,
  input wire [7:0]    mem_wdata,
  input wire [7:0]    mem_rdata,
  input wire          mem_ack
);
  reg  [31:0] cmd_reg;
  reg  [7:0]  rd_reg;
  wire        go;
  wire        rd_ack;
  assign go = psel && penable && pwrite && paddr == {AW{1'b0}} && !mem_req
              && pwdata[2:0] <= `OSM_OP_LDI;
  assign rd_ack = mem_ack && !mem_we;
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      cmd_reg <= 32'h0;
      rd_reg  <= 8'h00;
    end else begin
      if (go)
        cmd_reg <= pwdata;
      if (mem_req && rd_ack)
        rd_reg <= mem_rdata;
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  launch_read_a: assert property (go |=> mem_req && !mem_we)
    else $error("command did not start a read");
  req_hold_a: assert property (mem_req && !mem_ack |=> mem_req
    && $stable(mem_addr) && $stable(mem_we)) else $error("request moved");
  wb_addr_a: assert property ($rose(mem_we) |-> mem_req
    && $stable(mem_addr)) else $error("write-back address changed");
  dest_acc_a: assert property (rd_ack && !cmd_reg[3] |=> !mem_req)
    else $error("write-back with target zero");
  dest_file_a: assert property (rd_ack && cmd_reg[3]
    && cmd_reg[2:0] != `OSM_OP_LDI |=> mem_req && mem_we)
    else $error("missing write-back");
  load_once_a: assert property (rd_ack
    && cmd_reg[2:0] == `OSM_OP_LDI |=> !mem_req)
    else $error("load did more than one access");
  shl_data_a: assert property ($rose(mem_we)
    && cmd_reg[2:0] == `OSM_OP_SHL |-> mem_wdata == {rd_reg[6:0], 1'b0})
    else $error("left shift data wrong");
  shr_data_a: assert property ($rose(mem_we)
    && cmd_reg[2:0] == `OSM_OP_SHR |-> mem_wdata == {1'b0, rd_reg[7:1]})
    else $error("right shift data wrong");
  copy_data_a: assert property ($rose(mem_we)
    && cmd_reg[2:0] == `OSM_OP_COPY |-> mem_wdata == rd_reg)
    else $error("copy data changed");
  file_addr_a: assert property ($rose(mem_req)
    && cmd_reg[2:0] != `OSM_OP_LDI && cmd_reg[22:17] != 6'h00
    |-> mem_addr[15:12] == 4'h0 && mem_addr[6:0] == cmd_reg[22:16])
    else $error("file address wrong");
endmodule
////////////////////////////////////////////////////////////////
bind osm_exec osm_exec_props #(.AW(AW)) osm_exec_props_inst (
  .mclk(mclk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .mem_req(mem_req),
  .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
  .mem_rdata(mem_rdata), .mem_ack(mem_ack));

// [testbench/osm_mem_model.sv]
// Purpose: Data memory on the far side of the exec slice
// Assumes: One request at a time, ack after lat+1 cycles
// Notes:   Idle read data is inverted so a stale byte never matches
`timescale 1ns/10ps
module osm_mem_model (
  input  wire        mclk,
  input  wire        sys_rst,
  input  wire        mem_req,
  input  wire        mem_we,
  input  wire [15:0] mem_addr,
  input  wire [7:0]  mem_wdata,
  output wire [7:0]  mem_rdata,
  input  wire [3:0]  lat,
  output reg         mem_ack
);
  reg [7:0] mem [0:65535];
  reg [7:0] q;
  reg [3:0] cnt;
  assign mem_rdata = mem_ack ? q : ~q;
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      mem_ack <= 1'b0;
      cnt     <= 4'h0;
      q       <= 8'h00;
    end else begin
      mem_ack <= 1'b0;
      if (mem_req && !mem_ack) begin
        if (cnt >= lat) begin
          mem_ack <= 1'b1;
          cnt     <= 4'h0;
          if (mem_we)
            mem[mem_addr] <= mem_wdata;
          else
            q <= mem[mem_addr];
        end else
          cnt <= cnt + 4'h1;
      end
    end
  end
endmodule
